/* File: src/rse_reset_error.sv */
// Purpose: Reset source combining, restart pin and fault pin of a radar sensor
// Assumes: pclk at 40 MHz; presetn follows reset_in_low; APB register access
// Notes:   Pin inputs pass two flip-flops; every output is a flip-flop
`timescale 1ns/1ps

//Behaviour
// (R1) External reset pin is active low and holds the whole device in reset.
// (R2) External reset captures boot-select pins to choose flash, debug or functional.
// (R3) Restart pin is an output but software can make it a reset input.
// (R4) Dog reset enable is cleared after reset; no dog reset until set.
// (R5) Dog time-out raises NMI or warm reset, per configuration.
// (R6) With NMI, handler logs first then requests software reset.
// (R7) Dog reset comes from tick time-out or enabled clock-compare error.
// (R8) Clock-compare counter checks internal clock against reference, flags mismatch.
// (R9) Writing software system reset register starts warm reset.
// (R10) Debug reset request acts as an internal reset source.
// (R11) With indication enabled, restart pin shows a reset has occurred.
// (R12) Low-severity fault always interrupts; drives fault pin only if configured. Code: irq only if its mask bit is set.
// (R13) High-severity fault always interrupts and always drives fault pin. Code: irq only if its mask bit is set.
// (R14) Fault pin drives low on error, otherwise released to pull-up.
// (R15) Monitor applies full reset for errors that need it.
// (R16) Restart pin tells host a reset is pending.
// (R17) Host reads fault condition over the register bus after fault pin asserts.
// (R18) Boot select captured at reset release, fixed until next external reset.
// (R19) Fault pin stays low until software clears fault or reset.
module rse_reset_error
   import rse_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  boot_select_pins,
   input  wire logic        soft_restart_pin_in,
   output logic             soft_restart_pin_out,
   output logic             soft_restart_pin_oe,
   output logic             fault_out_low_out,
   output logic             fault_out_low_oe,
   input  wire logic        debug_reset_request,
   input  wire logic        tick_timeout_reset,
   input  wire logic        ref_clk_tick,
   input  wire logic        fault_low_event,
   input  wire logic        fault_high_event,
   output logic             warm_reset,
   output logic             dog_nmi,
   output logic             irq
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   rse_ctrl_type          ctrl;
   logic [ST_WIDTH-1:0]   status;
   logic [ST_WIDTH-1:0]   mask;
   rse_fault_type         fault_latch;
   rse_fault_type         next_latch;
   logic [1:0]            fault_clr;
   logic [1:0]            boot_sync1, boot_sync2;
   logic [1:0]            boot_wait;
   rse_boot_type          boot_mode;
   logic [1:0]            pin_sync, ref_sync;
   logic                  ref_prev;
   logic [15:0]           ref_count, int_count, ccc_expect;
   logic                  ccc_error;
   logic                  dog_event;
   logic                  warm_request;
   logic [7:0]            warm_count;
   logic                  wr_en, rd_en;
   logic                  addr_ok;
   logic [ST_WIDTH-1:0]   next_status;
   logic [ST_WIDTH-1:0]   status_set;
   logic [ST_WIDTH-1:0]   status_clr;
   logic                  ref_edge;
   logic [15:0]           ccc_diff;

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   // Zero-wait slave: access phase completes at once
   assign wr_en = clk_en & psel & penable & pwrite;
   assign rd_en = clk_en & psel & penable & ~pwrite;
   always_comb begin
      unique case (paddr)
         CTRL_OFFSET, STATUS_OFFSET, MASK_OFFSET, SWRST_OFFSET,
         BOOT_OFFSET, FAULT_OFFSET, CLKCMP_OFFSET: addr_ok = 1'b1;
         default:                                  addr_ok = 1'b0;
      endcase
   end

   // Ready and error answer, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
      end
   end

   // Read data, captured in the setup cycle so it stands during access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (clk_en && psel && !penable && !pwrite) begin
         unique case (paddr)
            CTRL_OFFSET:   prdata <= {26'h0, ctrl};
            STATUS_OFFSET: prdata <= {27'h0, status};                   // R17
            MASK_OFFSET:   prdata <= {27'h0, mask};
            BOOT_OFFSET:   prdata <= {30'h0, boot_mode};
            FAULT_OFFSET:  prdata <= {30'h0, fault_latch};              // R17
            CLKCMP_OFFSET: prdata <= {16'h0, ccc_expect};
            default:       prdata <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   // Configuration; dog enable comes out of reset cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= rse_ctrl_type'(CTRL_RESET);                            // R4
      end else if (wr_en && paddr == CTRL_OFFSET) begin
         ctrl <= rse_ctrl_type'(pwdata[5:0]);
      end
   end

   // Interrupt mask and clock-compare expectation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask       <= MASK_RESET;
         ccc_expect <= CCC_EXPECT_RESET;
      end else if (wr_en) begin
         if (paddr == MASK_OFFSET)   mask       <= pwdata[ST_WIDTH-1:0];
         if (paddr == CLKCMP_OFFSET) ccc_expect <= pwdata[15:0];
      end
   end

   // ----------------------------------------------------------------------
   // Pin synchronisers and boot-select capture
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_sync1 <= 2'h0;
         boot_sync2 <= 2'h0;
         pin_sync   <= 2'h0;
         ref_sync   <= 2'h0;
      end else if (clk_en) begin
         boot_sync1 <= boot_select_pins;
         boot_sync2 <= boot_sync1;
         pin_sync   <= {pin_sync[0], soft_restart_pin_in};
         ref_sync   <= {ref_sync[0], ref_clk_tick};
      end
   end

   // Capture once the synchronisers hold the pin levels, then hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin                                               // R1
         boot_wait <= 2'h0;
         boot_mode <= BOOT_FUNCTIONAL;
      end else if (clk_en && boot_wait != 2'h3) begin
         boot_wait <= boot_wait + 2'h1;                                 // R18
         if (boot_wait == 2'h2) boot_mode <= rse_boot_type'(boot_sync2); // R2
      end
   end

   // ----------------------------------------------------------------------
   // Clock-compare counter
   // ----------------------------------------------------------------------
   assign ref_edge = ref_sync[1] & ~ref_prev;
   assign ccc_diff = (int_count > ccc_expect) ? int_count - ccc_expect
                                              : ccc_expect - int_count;

   // Count internal cycles over a window of reference edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_prev  <= 1'b0;
         ref_count <= 16'h0;
         int_count <= 16'h0;
         ccc_error <= 1'b0;
      end else if (clk_en) begin
         ref_prev  <= ref_sync[1];
         ccc_error <= 1'b0;
         if (ref_edge && ref_count == CCC_WINDOW - 16'h1) begin
            ref_count <= 16'h0;
            int_count <= 16'h0;
            ccc_error <= (ccc_diff > CCC_TOL);                          // R8
         end else begin
            if (ref_edge) ref_count <= ref_count + 16'h1;
            int_count <= (int_count == 16'hffff) ? int_count : int_count + 16'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Reset sources
   // ----------------------------------------------------------------------
   // Dog event: tick time-out or enabled clock-compare error
   assign dog_event = ctrl.dog_en &
                      (tick_timeout_reset | (ctrl.ccc_en & ccc_error)); // R7

   // Software write, debug request, pin input or dog time-out
   always_comb begin
      warm_request = (wr_en && paddr == SWRST_OFFSET && pwdata[SWRST_GO_BIT]) // R9 R6
                   | (clk_en & debug_reset_request)                     // R10
                   | (clk_en & ctrl.pin_in & pin_sync[1])               // R3
                   | (clk_en & dog_event & ~ctrl.dog_nmi);              // R5
   end

   // NMI pulse for the dog time-out when configured
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dog_nmi <= 1'b0;
      end else if (clk_en) begin
         dog_nmi <= dog_event & ctrl.dog_nmi;                           // R5
      end
   end

   // Warm reset held for a fixed count after the last request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warm_count <= 8'h0;
         warm_reset <= 1'b0;
      end else if (clk_en) begin
         if (warm_request) begin
            warm_count <= WARM_HOLD_CYCLES;
            warm_reset <= 1'b1;
         end else if (warm_count != 8'h0) begin
            warm_count <= warm_count - 8'h1;
            warm_reset <= (warm_count != 8'h1);
         end
      end
   end

   // Restart pin: output indication unless turned into an input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_restart_pin_out <= 1'b1;                                  // R11
         soft_restart_pin_oe  <= 1'b1;
      end else if (clk_en) begin
         soft_restart_pin_oe  <= ~ctrl.pin_in;                          // R3
         soft_restart_pin_out <= ctrl.ind_en & (warm_request | warm_reset); // R11 R16
      end
   end

   // ----------------------------------------------------------------------
   // Faults, status and interrupt
   // ----------------------------------------------------------------------
   assign status_set = {warm_request, clk_en & fault_high_event,
                        clk_en & fault_low_event, clk_en & ccc_error,
                        clk_en & dog_event};                            // R12 R13
   assign status_clr = (wr_en && paddr == STATUS_OFFSET) ? pwdata[ST_WIDTH-1:0]
                                                         : '0;
   assign next_status = (status & ~status_clr) | status_set;            // Set wins

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
         irq    <= 1'b0;
      end else if (clk_en) begin
         status <= next_status;
         irq    <= |(next_status & mask);
      end
   end

   // Next fault latch: writing one clears, a same-cycle event wins over it
   assign fault_clr  = (wr_en && paddr == FAULT_OFFSET) ? pwdata[1:0] : 2'h0;
   assign next_latch = next_fault(fault_latch & ~fault_clr, fault_high_event,
                                  fault_low_event & ctrl.low_out);      // R12 R13 R19

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_latch <= '0;
      end else if (clk_en) begin
         fault_latch <= next_latch;                                     // R19
      end
   end

   // Open-drain fault pin: drive low while any fault is latched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_out_low_out <= 1'b0;
         fault_out_low_oe  <= 1'b0;
      end else if (clk_en) begin
         fault_out_low_out <= 1'b0;                                     // R14
         fault_out_low_oe  <= |next_latch;                              // R14 R19
      end
   end

   // Next latch value including same-cycle events
   function automatic logic [1:0] next_fault(input rse_fault_type f, input logic h,
                                             input logic l);
      next_fault = {f.high | h, f.low | l};
   endfunction

endmodule : rse_reset_error

/* File: src/rse_pkg.sv */
// Purpose: Constants and carrier types for the reset and error signalling block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   All offsets, field positions and reset values are named here once
package rse_pkg;

   // ----------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET    = 8'h00;
   localparam logic [7:0] STATUS_OFFSET  = 8'h04;
   localparam logic [7:0] MASK_OFFSET    = 8'h08;
   localparam logic [7:0] SWRST_OFFSET   = 8'h0c;
   localparam logic [7:0] BOOT_OFFSET    = 8'h10;
   localparam logic [7:0] FAULT_OFFSET   = 8'h14;
   localparam logic [7:0] CLKCMP_OFFSET  = 8'h18;

   // ----------------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------------
   localparam int CTRL_DOG_EN_BIT    = 0; // dog_reset_enable
   localparam int CTRL_DOG_NMI_BIT   = 1; // Time-out gives NMI instead of warm reset
   localparam int CTRL_CCC_EN_BIT    = 2; // Clock-compare error feeds dog reset
   localparam int CTRL_PIN_IN_BIT    = 3; // Restart pin turned into reset input
   localparam int CTRL_IND_EN_BIT    = 4; // Restart pin indication enable
   localparam int CTRL_LOW_OUT_BIT   = 5; // Low-severity faults drive fault pin
   localparam logic [5:0] CTRL_RESET = 6'h10;

   // ----------------------------------------------------------------------
   // Status / mask fields (status sticky, write one to clear; mask plain read/write)
   // ----------------------------------------------------------------------
   localparam int ST_DOG_BIT   = 0;
   localparam int ST_CCC_BIT   = 1;
   localparam int ST_LOW_BIT   = 2;
   localparam int ST_HIGH_BIT  = 3;
   localparam int ST_WARM_BIT  = 4;
   localparam int ST_WIDTH     = 5;
   localparam logic [4:0] MASK_RESET = 5'h00;

   // Software reset write key, bit 0 of a write starts the warm reset
   localparam int SWRST_GO_BIT = 0;

   // ----------------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------------
   localparam int unsigned   WARM_HOLD_NS     = 1000;
   localparam int unsigned   CLK_PERIOD_NS    = 25;
   localparam logic [7:0]    WARM_HOLD_CYCLES = 8'((WARM_HOLD_NS + CLK_PERIOD_NS - 1)
                                                   / CLK_PERIOD_NS);
   localparam logic [15:0]   CCC_WINDOW       = 16'h0400; // Reference edges per window
   localparam logic [15:0]   CCC_EXPECT_RESET = 16'h0400; // Internal edges expected
   localparam logic [15:0]   CCC_TOL          = 16'h0004; // Allowed difference

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      BOOT_FUNCTIONAL = 2'b00,
      BOOT_FLASHING   = 2'b01,
      BOOT_DEBUGGING  = 2'b10,
      BOOT_RESERVED   = 2'b11
   } rse_boot_type;

   typedef struct packed {
      logic low_out;  // Bit 5; fields listed from the top bit down
      logic ind_en;
      logic pin_in;
      logic ccc_en;
      logic dog_nmi;
      logic dog_en;
   } rse_ctrl_type;

   typedef struct packed {
      logic high;     // Bit 1 of the fault register
      logic low;
   } rse_fault_type;

endpackage : rse_pkg

/* File: testbench/rse_reset_error_asserts.sv */
// Purpose: Concurrent checks on bus answers, warm reset and fault pin
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Attached to every rse_reset_error by bind
`timescale 1ns/1ps
module rse_reset_error_chk
   import rse_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        soft_restart_pin_in,
   input wire logic        soft_restart_pin_oe,
   input wire logic        fault_out_low_out,
   input wire logic        fault_out_low_oe,
   input wire logic        fault_high_event,
   input wire logic        debug_reset_request,
   input wire logic        warm_reset,
   input wire logic        dog_nmi
);
   // ---------------------------------------------------------------
   // Helper state
   // ---------------------------------------------------------------
   logic       ctrl_seen;
   logic [7:0] warm_cnt;
   wire        wr_done  = psel && penable && pready && pwrite;
   wire        fault_wr = wr_done && paddr == FAULT_OFFSET;

   // Marks the first control write since reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_seen <= 1'b0;
      else if (wr_done && paddr == CTRL_OFFSET) ctrl_seen <= 1'b1;
   end

   // Length of the running warm reset, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) warm_cnt <= 8'h00;
      else if (!warm_reset) warm_cnt <= 8'h00;
      else if (warm_cnt != 8'hff) warm_cnt <= warm_cnt + 8'h01;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence setup_s;
      psel && !penable && clk_en;
   endsequence
   sequence pin_req_s;
      (!soft_restart_pin_oe && soft_restart_pin_in && clk_en) [*3];
   endsequence

   chk_apb_answer: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   chk_bad_addr: assert property (setup_s ##0 (paddr > CLKCMP_OFFSET || paddr[1:0] != 2'h0)
      |=> pready && pslverr) else $error("unmapped access not refused");
   chk_high_pin: assert property (fault_high_event && clk_en |=> fault_out_low_oe)
      else $error("high fault did not drive pin");
   chk_pin_low: assert property (fault_out_low_oe |-> !fault_out_low_out)
      else $error("fault pin driven high");
   chk_fault_hold: assert property (fault_out_low_oe && !fault_wr |=> fault_out_low_oe)
      else $error("fault pin released without clear");
   chk_swrst_warm: assert property (wr_done && paddr == SWRST_OFFSET
      && pwdata[SWRST_GO_BIT] && clk_en |-> ##[1:3] warm_reset) else $error("no soft warm");
   chk_debug_warm: assert property (debug_reset_request && clk_en |-> ##[1:3] warm_reset)
      else $error("debug request ignored");
   chk_pin_input: assert property (pin_req_s |-> ##[1:4] warm_reset)
      else $error("restart pin input ignored");
   chk_dog_gated: assert property (!ctrl_seen |-> !dog_nmi)
      else $error("dog active before enable");
   chk_warm_len: assert property ($fell(warm_reset) |-> warm_cnt >= WARM_HOLD_CYCLES - 8'h01)
      else $error("warm reset too short");
endmodule // rse_reset_error_chk

bind rse_reset_error rse_reset_error_chk chk (
   .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
   .soft_restart_pin_in, .soft_restart_pin_oe, .fault_out_low_out, .fault_out_low_oe,
   .fault_high_event, .debug_reset_request, .warm_reset, .dog_nmi
);

/* File: testbench/rse_host_model.sv */
// Purpose: Host and supervisor side of the restart and fault pins
// Assumes: Fault line has a pull-up; host drives the restart line when released
// Notes:   Pulls the device reset once a fault has stood for eight cycles
`timescale 1ns/1ps
module rse_host_model (
   input  wire logic pclk,
   input  wire logic fault_out_low_out,
   input  wire logic fault_out_low_oe,
   input  wire logic soft_restart_pin_out,
   input  wire logic soft_restart_pin_oe,
   input  wire logic host_level,
   input  wire logic recover_en,
   output logic      fault_line,
   output logic      restart_line,
   output logic      reset_in_low
);
   logic [3:0] low_cnt = 4'h0;

   // Wired levels of the two pins
   assign fault_line   = fault_out_low_oe ? fault_out_low_out : 1'b1;
   assign restart_line = soft_restart_pin_oe ? soft_restart_pin_out : host_level;

   // Supervisor counts fault cycles, then applies a full reset
   always_ff @(posedge pclk) begin
      low_cnt <= (recover_en && !fault_line) ? low_cnt + 4'h1 : 4'h0;
   end
   assign reset_in_low = (low_cnt != 4'h8);
endmodule // rse_host_model

/* File: testbench/rse_reset_error_bench.sv */
// Purpose: Self-checking bench for the reset and fault signalling block
// Assumes: 40 MHz pclk, APB master tasks, host model on the pins
// Notes:   Random mask values come from a fixed seed
`timescale 1ns/1ps
module rse_reset_error_bench
   import rse_pkg::*;
;
   logic        pclk = 1'b0, bench_rstn = 1'b0, clk_en = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, warm_reset, dog_nmi, irq, reset_in_low;
   logic [1:0]  boot_select_pins = 2'h0;
   logic [3:0]  ev = 4'h0;
   logic        host_level = 1'b0, recover_en = 1'b0, ref_run = 1'b0, ref_clk_tick = 1'b0;
   logic        restart_out, restart_oe, fault_out, fault_oe, fault_line, restart_line;
   wire         presetn = bench_rstn & reset_in_low;
   int          mismatches = 0, n_checks = 0, nmi_cnt = 0, warm_hi = 0;
   int          run = 0, last_run = 0, ind_hits = 0;

   rse_reset_error uut (
      .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .boot_select_pins, .soft_restart_pin_in(restart_line),
      .soft_restart_pin_out(restart_out), .soft_restart_pin_oe(restart_oe),
      .fault_out_low_out(fault_out), .fault_out_low_oe(fault_oe),
      .debug_reset_request(ev[1]), .tick_timeout_reset(ev[0]), .ref_clk_tick,
      .fault_low_event(ev[2]), .fault_high_event(ev[3]), .warm_reset, .dog_nmi, .irq
   );
   rse_host_model host (
      .pclk, .fault_out_low_out(fault_out), .fault_out_low_oe(fault_oe),
      .soft_restart_pin_out(restart_out), .soft_restart_pin_oe(restart_oe),
      .host_level, .recover_en, .fault_line, .restart_line, .reset_in_low
   );

   // ---------------------------------------------------------------
   // Clock, monitors and tasks
   // ---------------------------------------------------------------
   initial begin
      forever #12.5 pclk = ~pclk;
   end

   // Counts pulses, warm runs and indications; toggles the reference
   always @(posedge pclk) begin
      if (dog_nmi === 1'b1) nmi_cnt++;
      if (warm_reset === 1'b1 && restart_out === 1'b1) ind_hits++;
      if (warm_reset === 1'b1) begin
         warm_hi++;
         run++;
      end else if (run != 0) begin
         last_run = run;
         run = 0;
      end
      if (ref_run) ref_clk_tick <= ~ref_clk_tick;
   end

   function automatic logic [31:0] bit_of(int b);
      return 32'h1 << b;
   endfunction

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // One APB transfer, then one idle edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      check("pready", pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic w(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(n, rd, e);
   endtask

   task automatic pulse(int k, int n);
      ev <= 4'h1 << k;
      @(posedge pclk);
      ev <= 4'h0;
      repeat (n) @(posedge pclk);
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      mismatches++;
      conclude();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] d;
      int n0, w0, i0;
      void'($urandom(18971));
      for (int i = 0; i < 3; i++) begin
         boot_select_pins <= i[1:0];
         bench_rstn <= 1'b0;
         repeat (4) @(posedge pclk);
         bench_rstn <= 1'b1;
         repeat (3) @(posedge pclk);
         rchk("boot mode", BOOT_OFFSET, i);
         boot_select_pins <= ~i[1:0];
         repeat (4) @(posedge pclk);
         rchk("boot held", BOOT_OFFSET, i);
      end
      rchk("ctrl reset", CTRL_OFFSET, 32'h10);
      rchk("mask reset", MASK_OFFSET, 32'h0);
      rchk("clkcmp reset", CLKCMP_OFFSET, 32'h400);
      apb(1'b0, 8'h1c, 32'h0);
      check("unmapped err", err, 1'b1);
      pulse(0, 50);
      check("nmi off", nmi_cnt, 0);
      check("warm off", warm_hi, 0);
      w(CTRL_OFFSET, bit_of(CTRL_DOG_EN_BIT) | bit_of(CTRL_IND_EN_BIT));
      pulse(0, 60);
      check("warm hold", last_run >= WARM_HOLD_CYCLES, 1'b1);
      check("indication", ind_hits > 0, 1'b1);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      check("dog status", rd[ST_DOG_BIT], 1'b1);
      w(STATUS_OFFSET, 32'h1f);
      w(CTRL_OFFSET, bit_of(CTRL_DOG_EN_BIT) | bit_of(CTRL_DOG_NMI_BIT));
      n0 = nmi_cnt;
      w0 = warm_hi;
      pulse(0, 10);
      check("nmi pulse", nmi_cnt, n0 + 1);
      check("nmi no warm", warm_hi, w0);
      w(SWRST_OFFSET, 32'h1);
      repeat (60) @(posedge pclk);
      check("soft warm", warm_hi - w0 >= WARM_HOLD_CYCLES, 1'b1);
      w(CTRL_OFFSET, 32'h0);
      w0 = warm_hi;
      i0 = ind_hits;
      pulse(1, 60);
      check("debug warm", warm_hi - w0 >= WARM_HOLD_CYCLES, 1'b1);
      check("no indication", ind_hits, i0);
      w(CTRL_OFFSET, 32'h07);
      w(CLKCMP_OFFSET, 32'h800);
      ref_run <= 1'b1;
      repeat (4200) @(posedge pclk);
      w(STATUS_OFFSET, 32'h1f);
      n0 = nmi_cnt;
      repeat (2100) @(posedge pclk);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      check("clock match", rd[ST_CCC_BIT], 1'b0);
      check("no clock nmi", nmi_cnt, n0);
      w(CLKCMP_OFFSET, 32'h0);
      repeat (4200) @(posedge pclk);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      check("clock error", rd[ST_CCC_BIT], 1'b1);
      check("clock nmi", nmi_cnt > n0, 1'b1);
      ref_run <= 1'b0;
      w(CTRL_OFFSET, 32'h0);
      w(STATUS_OFFSET, 32'h1f);
      w(MASK_OFFSET, bit_of(ST_LOW_BIT));
      pulse(2, 3);
      check("low no pin", fault_line, 1'b1);
      check("low irq", irq, 1'b1);
      w(STATUS_OFFSET, 32'h1f);
      check("irq clear", irq, 1'b0);
      w(CTRL_OFFSET, bit_of(CTRL_LOW_OUT_BIT));
      pulse(2, 3);
      check("low pin", fault_line, 1'b0);
      pulse(3, 20);
      check("pin held", fault_line, 1'b0);
      rchk("fault latch", FAULT_OFFSET, 32'h3);
      w(FAULT_OFFSET, 32'h3);
      check("pin released", fault_line, 1'b1);
      clk_en <= 1'b0;
      pulse(3, 3);
      check("frozen", fault_line, 1'b1);
      clk_en <= 1'b1;
      w(CTRL_OFFSET, bit_of(CTRL_PIN_IN_BIT));
      @(posedge pclk);
      check("pin input", restart_oe, 1'b0);
      w0 = warm_hi;
      host_level <= 1'b1;
      repeat (5) @(posedge pclk);
      host_level <= 1'b0;
      repeat (60) @(posedge pclk);
      check("pin reset", warm_hi - w0 >= WARM_HOLD_CYCLES, 1'b1);
      w(STATUS_OFFSET, 32'h1f);
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         w(MASK_OFFSET, d);
         rchk("mask", MASK_OFFSET, d & 32'h1f);
         pulse(3, 3);
         check("high irq", irq, d[ST_HIGH_BIT]);
         w(FAULT_OFFSET, 32'h3);
         w(STATUS_OFFSET, 32'h1f);
      end
      recover_en <= 1'b1;
      pulse(3, 30);
      rchk("recovered", CTRL_OFFSET, 32'h10);
      check("pin free", fault_line, 1'b1);
      recover_en <= 1'b0;
      conclude();
   end
endmodule // rse_reset_error_bench
